// ---- core/mbag_bitrev_add.sv ----
// reversed-carry adder of pointer and pivot
// assumes the pivot is half the buffer in words
`timescale 1ns/1ps
module mbag_bitrev_add (
    input wire logic [15:0] ptr,
    input wire logic [14:0] pivot,
    output logic [15:0] sum
);
    logic [14:0] ptr_rev;
    logic [14:0] mod_rev;
    logic [14:0] sum_rev;

    genvar i;
    generate
        // word addresses: pivot moves to bits 15:1, bit 0 stays out of the carry chain
        for (i = 0; i < 15; i++) begin : g_rev
            assign ptr_rev[i] = ptr[15 - i];
            assign mod_rev[i] = pivot[14 - i];
            assign sum[15 - i] = sum_rev[i];
        end
    endgenerate
    assign sum_rev = ptr_rev + mod_rev;
    assign sum[0] = 1'b0;
endmodule : mbag_bitrev_add

// ---- core/mbag_modulo_corr.sv ----
// modulo correction for one generator, combinational
// assumes start even and end odd
`timescale 1ns/1ps
module mbag_modulo_corr (
    input wire logic enable,
    input wire logic [15:0] addr,
    input wire logic [15:0] buf_start,
    input wire logic [15:0] buf_end,
    output logic [15:0] addr_out,
    output logic corrected
);
    logic [15:0] span;
    logic [15:0] mask;
    logic [16:0] len;
    logic inc_ok;
    logic dec_ok;
    logic fix_up;
    logic fix_low;
    logic [16:0] up_val;
    logic [16:0] low_val;

    assign span = buf_end - buf_start;
    assign len = {1'b0, span} + 17'h00001;
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_mask
            assign mask[i] = |span[15:i];
        end
    endgenerate
    // buffer direction follows from how the boundaries are aligned
    assign inc_ok = (buf_start & mask) == 16'h0000;
    assign dec_ok = (buf_end & mask) == mask;
    // aligned both ways means both boundaries are checked
    assign fix_up = enable && (inc_ok || !dec_ok) && (addr > buf_end);
    assign fix_low = enable && dec_ok && (addr < buf_start);
    // a remainder rather than one subtraction, so any overshoot folds back
    assign up_val = {1'b0, buf_start} + (({1'b0, addr} - {1'b0, buf_start}) % len);
    assign low_val = {1'b0, buf_end} - (({1'b0, buf_end} - {1'b0, addr}) % len);
    assign addr_out = fix_up ? up_val[15:0] : (fix_low ? low_val[15:0] : addr);
    assign corrected = fix_up || fix_low;
endmodule : mbag_modulo_corr

// ---- core/mbag_top.sv ----
// address generator top: AXI4-Lite registers and three generators
// assumes decode requests on aclk, results used a cycle later
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module mbag_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mbag_pkg::mbag_req_t x_rd_req,
    input wire mbag_pkg::mbag_req_t x_wr_req,
    input wire mbag_pkg::mbag_req_t y_req,
    output mbag_pkg::mbag_rsp_t x_rd_rsp,
    output mbag_pkg::mbag_rsp_t x_wr_rsp,
    output mbag_pkg::mbag_rsp_t y_rsp
);
    logic [15:0] ctrl_r;
    logic [15:0] pivot_r;
    logic [15:0] xstart_r;
    logic [15:0] xend_r;
    logic [15:0] ystart_r;
    logic [15:0] yend_r;
    logic [15:0] fix_cnt_r;
    logic [15:0] fix_cnt_nxt;

    logic aw_hold_r;
    logic [7:0] aw_addr_r;
    logic w_hold_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_commit;
    logic wr_hit;

    mbag_pkg::mbag_rsp_t x_rd_rsp_r;
    mbag_pkg::mbag_rsp_t x_wr_rsp_r;
    mbag_pkg::mbag_rsp_t y_rsp_r;
    mbag_pkg::mbag_rsp_t x_rd_nxt;
    mbag_pkg::mbag_rsp_t x_wr_nxt;
    mbag_pkg::mbag_rsp_t y_nxt;

    logic [3:0] x_sel;
    logic [3:0] y_sel;
    logic [3:0] b_sel;
    logic x_mod_active;
    logic y_mod_active;
    logic bitrev_enabled;
    logic [14:0] pivot;
    logic bitrev_on;
    logic x_rd_mod_on;
    logic x_wr_mod_on;
    logic y_mod_on;
    logic [15:0] x_rd_sum;
    logic [15:0] x_wr_sum;
    logic [15:0] y_sum;
    logic [15:0] x_rd_fixed;
    logic [15:0] x_wr_fixed;
    logic [15:0] y_fixed;
    logic x_rd_corr;
    logic x_wr_corr;
    logic y_corr;
    logic [15:0] brev_sum;
    logic [15:0] xstart_eff;
    logic [15:0] xend_eff;
    logic [15:0] ystart_eff;
    logic [15:0] yend_eff;

    // control field decode
    assign x_sel = ctrl_r[mbag_pkg::CTRL_XSEL_LSB +: 4];
    assign y_sel = ctrl_r[mbag_pkg::CTRL_YSEL_LSB +: 4];
    assign b_sel = ctrl_r[mbag_pkg::CTRL_BSEL_LSB +: 4];
    assign x_mod_active = (x_sel != mbag_pkg::SEL_OFF) && ctrl_r[mbag_pkg::CTRL_XEN_BIT];
    assign y_mod_active = (y_sel != mbag_pkg::SEL_OFF) && ctrl_r[mbag_pkg::CTRL_YEN_BIT];
    assign bitrev_enabled = (b_sel != mbag_pkg::SEL_OFF) && pivot_r[mbag_pkg::PIV_EN_BIT];
    assign pivot = pivot_r[mbag_pkg::PIV_LSB +: 15];

    // start forced even, end odd
    assign xstart_eff = {xstart_r[15:1], 1'b0};
    assign xend_eff = {xend_r[15:1], 1'b1};
    assign ystart_eff = {ystart_r[15:1], 1'b0};
    assign yend_eff = {yend_r[15:1], 1'b1};

    // word writes through the selected pointer, increment modes only
    assign bitrev_on = bitrev_enabled && (x_wr_req.wreg == b_sel) && !x_wr_req.is_byte
        && (x_wr_req.mode == mbag_pkg::MBAG_AM_PRE_INC
        || x_wr_req.mode == mbag_pkg::MBAG_AM_POST_INC);

    assign x_rd_mod_on = x_mod_active && (x_rd_req.wreg == x_sel);
    assign x_wr_mod_on = x_mod_active && (x_wr_req.wreg == x_sel) && !bitrev_on;
    assign y_mod_on = y_mod_active && (y_req.wreg == y_sel);

    assign x_rd_sum = x_rd_req.ptr + x_rd_req.step;
    assign x_wr_sum = x_wr_req.ptr + x_wr_req.step;
    assign y_sum = y_req.ptr + y_req.step;

    mbag_modulo_corr u_x_rd_mod (
        .enable(x_rd_mod_on),
        .addr(x_rd_sum),
        .buf_start(xstart_eff),
        .buf_end(xend_eff),
        .addr_out(x_rd_fixed),
        .corrected(x_rd_corr)
    );

    mbag_modulo_corr u_x_wr_mod (
        .enable(x_wr_mod_on),
        .addr(x_wr_sum),
        .buf_start(xstart_eff),
        .buf_end(xend_eff),
        .addr_out(x_wr_fixed),
        .corrected(x_wr_corr)
    );

    mbag_modulo_corr u_y_mod (
        .enable(y_mod_on),
        .addr(y_sum),
        .buf_start(ystart_eff),
        .buf_end(yend_eff),
        .addr_out(y_fixed),
        .corrected(y_corr)
    );

    mbag_bitrev_add u_brev (
        .ptr(x_wr_req.ptr),
        .pivot(pivot),
        .sum(brev_sum)
    );

    // builds the answer of one generator from the request and the corrected sum
    function automatic mbag_pkg::mbag_rsp_t form_rsp(
        input mbag_pkg::mbag_req_t q,
        input logic [15:0] sum,
        input logic fixed
    );
        mbag_pkg::mbag_rsp_t r;
        r.valid = q.valid;
        r.ea = q.ptr;
        r.wb_en = 1'b0;
        r.wb_val = q.ptr;
        r.mod_fixed = 1'b0;
        r.bitrev_used = 1'b0;
        case (q.mode)
            mbag_pkg::MBAG_AM_PRE_INC, mbag_pkg::MBAG_AM_PRE_DEC: begin
                r.ea = sum;
                r.wb_en = q.valid;
                r.wb_val = sum;
                r.mod_fixed = fixed;
            end
            mbag_pkg::MBAG_AM_POST_INC, mbag_pkg::MBAG_AM_POST_DEC: begin
                r.wb_en = q.valid;
                r.wb_val = sum;
                r.mod_fixed = fixed;
            end
            mbag_pkg::MBAG_AM_OFFSET: begin
                // the access sees the corrected address, the pointer keeps its value
                r.ea = sum;
                r.mod_fixed = fixed;
            end
            default: begin
                r.ea = q.ptr;
            end
        endcase
        return r;
    endfunction : form_rsp

    always_comb begin
        x_rd_nxt = form_rsp(x_rd_req, x_rd_fixed, x_rd_corr);
    end

    always_comb begin
        x_wr_nxt = form_rsp(x_wr_req, x_wr_fixed, x_wr_corr);
        if (bitrev_on) begin
            // the normal step is dropped, the pivot is the only modifier
            x_wr_nxt.wb_val = brev_sum;
            x_wr_nxt.bitrev_used = x_wr_req.valid;
            x_wr_nxt.mod_fixed = 1'b0;
            if (x_wr_req.mode == mbag_pkg::MBAG_AM_PRE_INC) begin
                x_wr_nxt.ea = brev_sum;
            end else begin
                x_wr_nxt.ea = {x_wr_req.ptr[15:1], 1'b0};
            end
        end
    end

    always_comb begin
        y_nxt = form_rsp(y_req, y_fixed, y_corr);
        if (y_mod_on) begin
            y_nxt.ea = {y_nxt.ea[15:1], 1'b0};
            y_nxt.wb_val = {y_nxt.wb_val[15:1], 1'b0};
        end
    end

    // results leave from flip-flops, one cycle after the request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            x_rd_rsp_r <= '0;
            x_wr_rsp_r <= '0;
            y_rsp_r <= '0;
        end else if (ce) begin
            x_rd_rsp_r <= x_rd_nxt;
            x_wr_rsp_r <= x_wr_nxt;
            y_rsp_r <= y_nxt;
        end
    end

    assign x_rd_rsp = x_rd_rsp_r;
    assign x_wr_rsp = x_wr_rsp_r;
    assign y_rsp = y_rsp_r;

    // wraps silently; software samples differences
    assign fix_cnt_nxt = fix_cnt_r
        + {15'h0000, x_rd_rsp_r.valid && x_rd_rsp_r.mod_fixed}
        + {15'h0000, x_wr_rsp_r.valid && x_wr_rsp_r.mod_fixed}
        + {15'h0000, y_rsp_r.valid && y_rsp_r.mod_fixed};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fix_cnt_r <= 16'h0000;
        end else if (ce) begin
            fix_cnt_r <= fix_cnt_nxt;
        end
    end

    // address and data taken in either order, held until both are in
    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign wr_commit = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_hit = aw_addr_r == mbag_pkg::OFF_CTRL || aw_addr_r == mbag_pkg::OFF_PIVOT
        || aw_addr_r == mbag_pkg::OFF_XSTART || aw_addr_r == mbag_pkg::OFF_XEND
        || aw_addr_r == mbag_pkg::OFF_YSTART || aw_addr_r == mbag_pkg::OFF_YEND
        || aw_addr_r == mbag_pkg::OFF_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[7:2], 2'h0};
            end else if (wr_commit) begin
                aw_hold_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end else if (wr_commit) begin
                w_hold_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= mbag_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_commit) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? mbag_pkg::RESP_OKAY : mbag_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // byte lanes 0 and 1 carry the 16-bit registers, upper lanes are ignored
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        return v;
    endfunction : merge16

    // a pivot rewrite while bit-reverse is on takes effect for the next request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= mbag_pkg::CTRL_RESET;
            pivot_r <= mbag_pkg::PIVOT_RESET;
            xstart_r <= mbag_pkg::BOUND_RESET;
            xend_r <= mbag_pkg::BOUND_RESET;
            ystart_r <= mbag_pkg::BOUND_RESET;
            yend_r <= mbag_pkg::BOUND_RESET;
        end else if (ce && wr_commit) begin
            case (aw_addr_r)
                mbag_pkg::OFF_CTRL: begin
                    ctrl_r <= merge16(ctrl_r, w_data_r, w_strb_r);
                end
                mbag_pkg::OFF_PIVOT: begin
                    pivot_r <= merge16(pivot_r, w_data_r, w_strb_r);
                end
                mbag_pkg::OFF_XSTART: begin
                    xstart_r <= merge16(xstart_r, w_data_r, w_strb_r);
                end
                mbag_pkg::OFF_XEND: begin
                    xend_r <= merge16(xend_r, w_data_r, w_strb_r);
                end
                mbag_pkg::OFF_YSTART: begin
                    ystart_r <= merge16(ystart_r, w_data_r, w_strb_r);
                end
                mbag_pkg::OFF_YEND: begin
                    yend_r <= merge16(yend_r, w_data_r, w_strb_r);
                end
                default: begin
                    ctrl_r <= ctrl_r;
                end
            endcase
        end
    end

    // read channel: one read at a time, answered the cycle after the address is taken
    assign s_axi_arready = !rvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= mbag_pkg::RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_r <= 1'b1;
                rresp_r <= mbag_pkg::RESP_OKAY;
                case ({s_axi_araddr[7:2], 2'h0})
                    mbag_pkg::OFF_CTRL: begin
                        rdata_r <= {16'h0000, ctrl_r};
                    end
                    mbag_pkg::OFF_PIVOT: begin
                        rdata_r <= {16'h0000, pivot_r};
                    end
                    mbag_pkg::OFF_XSTART: begin
                        rdata_r <= {16'h0000, xstart_r};
                    end
                    mbag_pkg::OFF_XEND: begin
                        rdata_r <= {16'h0000, xend_r};
                    end
                    mbag_pkg::OFF_YSTART: begin
                        rdata_r <= {16'h0000, ystart_r};
                    end
                    mbag_pkg::OFF_YEND: begin
                        rdata_r <= {16'h0000, yend_r};
                    end
                    mbag_pkg::OFF_STATUS: begin
                        rdata_r <= 32'h00000000;
                        rdata_r[mbag_pkg::STAT_CNT_LSB +: 16] <= fix_cnt_r;
                        rdata_r[2:0] <= {bitrev_enabled, y_mod_active, x_mod_active};
                    end
                    default: begin
                        rdata_r <= 32'h00000000;
                        rresp_r <= mbag_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
endmodule : mbag_top

// ---- shared/mbag_pkg.sv ----
// constants and carrier types of the address generator
// assumes one core clock and one request per generator per cycle
// Behaviour
// - x selector in control 3:0; 15 disables x modulo.
// - x modulo needs selector not 15 and bit 15.
// - y selector in 7:4; y modulo needs not 15 and bit 14.
// - boundary test is beyond, not equal.
// - any overshoot is corrected.
// - write-back only in pre or post modify modes.
// - increment needs zero low start bits, decrement ones in end.
// - incrementing buffer corrects at upper boundary only.
// - decrementing buffer corrects at lower boundary only.
// - both directions only for power-of-two buffers.
// - bit-reverse only in the x write generator.
// - only the modifier is bit-reversed.
// - bit-reverse needs selector not 15, pivot bit 15, increment indirect.
// - 15-bit pivot in pivot register bits 14:0.
// - pivot is half the buffer size in words.
// - bit-reversed results are word addresses, pivot scaled to bytes.
// - byte writes or other modes give normal addresses.
// - bit-reverse adds pivot with reversed carry, step ignored.
// - bit-reverse overrides modulo in x write, not x read.
// - four 16-bit start and end byte boundary registers.
// - y modulo addresses keep the lsb clear.
package mbag_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PIVOT = 8'h04;
    localparam logic [7:0] OFF_XSTART = 8'h08;
    localparam logic [7:0] OFF_XEND = 8'h0C;
    localparam logic [7:0] OFF_YSTART = 8'h10;
    localparam logic [7:0] OFF_YEND = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam int CTRL_XSEL_LSB = 0;
    localparam int CTRL_YSEL_LSB = 4;
    localparam int CTRL_BSEL_LSB = 8;
    localparam int CTRL_YEN_BIT = 14;
    localparam int CTRL_XEN_BIT = 15;
    localparam int PIV_LSB = 0;
    localparam int PIV_EN_BIT = 15;
    localparam int STAT_CNT_LSB = 16;
    localparam logic [3:0] SEL_OFF = 4'hF;
    localparam logic [15:0] CTRL_RESET = 16'h0FFF;
    localparam logic [15:0] PIVOT_RESET = 16'h0000;
    localparam logic [15:0] BOUND_RESET = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MBAG_AM_IND,
        MBAG_AM_PRE_INC,
        MBAG_AM_PRE_DEC,
        MBAG_AM_POST_INC,
        MBAG_AM_POST_DEC,
        MBAG_AM_OFFSET
    } mbag_mode_t;

    typedef struct packed {
        logic valid;
        logic [3:0] wreg;
        logic [15:0] ptr;
        logic [15:0] step;
        mbag_mode_t mode;
        logic is_byte;
    } mbag_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] ea;
        logic wb_en;
        logic [15:0] wb_val;
        logic mod_fixed;
        logic bitrev_used;
    } mbag_rsp_t;
endpackage : mbag_pkg

// ---- verification/mbag_checker.sv ----
// port assertions, bound onto the top
// assumes ce stays high
`timescale 1ns/1ps
module mbag_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire mbag_pkg::mbag_req_t x_rd_req,
    input wire mbag_pkg::mbag_req_t x_wr_req,
    input wire mbag_pkg::mbag_rsp_t x_rd_rsp,
    input wire mbag_pkg::mbag_rsp_t x_wr_rsp,
    input wire mbag_pkg::mbag_rsp_t y_rsp
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic v;
    mbag_pkg::mbag_mode_t m;
    assign v = x_rd_req.valid;
    assign m = x_rd_req.mode;
    a_ind_keep: assert property (v && m == mbag_pkg::MBAG_AM_IND |=> !x_rd_rsp.wb_en)
        else $error("indirect wrote pointer");
    a_off_keep: assert property (v && m == mbag_pkg::MBAG_AM_OFFSET |=> !x_rd_rsp.wb_en)
        else $error("offset wrote pointer");
    a_post_ea: assert property (v && m == mbag_pkg::MBAG_AM_POST_INC
        |=> x_rd_rsp.wb_en && x_rd_rsp.ea == $past(x_rd_req.ptr)) else $error("post mode wrong");
    a_pre_ea: assert property (v && m == mbag_pkg::MBAG_AM_PRE_INC
        |=> x_rd_rsp.wb_en && x_rd_rsp.ea == x_rd_rsp.wb_val) else $error("pre mode wrong");
    a_plain_sum: assert property (v && m == mbag_pkg::MBAG_AM_PRE_INC ##1 !x_rd_rsp.mod_fixed
        |-> x_rd_rsp.ea == $past(x_rd_req.ptr) + $past(x_rd_req.step)) else $error("sum wrong");
    a_no_rd_brev: assert property (!x_rd_rsp.bitrev_used && !y_rsp.bitrev_used)
        else $error("reversed carry outside x write");
    a_byte_plain: assert property (x_wr_req.valid && x_wr_req.is_byte |=> !x_wr_rsp.bitrev_used)
        else $error("byte write used reversed carry");
    a_brev_word: assert property (x_wr_rsp.bitrev_used |-> !x_wr_rsp.wb_val[0] && !x_wr_rsp.mod_fixed)
        else $error("reversed write not word");
    a_y_word: assert property (y_rsp.valid && y_rsp.mod_fixed |-> !y_rsp.ea[0])
        else $error("y corrected address is odd");
endmodule : mbag_checker
bind mbag_top mbag_checker u_chk (.aclk(aclk), .aresetn(aresetn), .x_rd_req(x_rd_req),
    .x_wr_req(x_wr_req), .x_rd_rsp(x_rd_rsp), .x_wr_rsp(x_wr_rsp), .y_rsp(y_rsp));

// ---- verification/mbag_decode_model.sv ----
// decode stand-in: feeds a request to chosen generators
// assumes cmd and go change just after a rising edge
`timescale 1ns/1ps
module mbag_decode_model (
    input wire logic aclk,
    input wire logic [2:0] go,
    input wire mbag_pkg::mbag_req_t cmd,
    output mbag_pkg::mbag_req_t x_rd_req,
    output mbag_pkg::mbag_req_t x_wr_req,
    output mbag_pkg::mbag_req_t y_req
);
    mbag_pkg::mbag_req_t idle;
    always_comb begin
        idle = cmd;
        // an idle slot must never look like a stale copy of the last request
        idle.valid = 1'b0;
        idle.ptr = ~cmd.ptr;
        idle.step = ~cmd.step;
    end
    initial {x_rd_req, x_wr_req, y_req} = '0;
    always @(posedge aclk) begin
        x_rd_req <= go[0] ? cmd : idle;
        x_wr_req <= go[1] ? cmd : idle;
        y_req <= go[2] ? cmd : idle;
    end
endmodule : mbag_decode_model

// ---- verification/testbench.sv ----
// self-checking bench of the address generator
// assumes the decode model feeds the block
`timescale 1ns/1ps
module testbench;
    localparam mbag_pkg::mbag_mode_t IN = mbag_pkg::MBAG_AM_IND;
    localparam mbag_pkg::mbag_mode_t PRI = mbag_pkg::MBAG_AM_PRE_INC;
    localparam mbag_pkg::mbag_mode_t PRD = mbag_pkg::MBAG_AM_PRE_DEC;
    localparam mbag_pkg::mbag_mode_t POI = mbag_pkg::MBAG_AM_POST_INC;
    localparam mbag_pkg::mbag_mode_t OF = mbag_pkg::MBAG_AM_OFFSET;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [1:0] bresp, rresp, r;
    logic [2:0] go = 3'h0;
    mbag_pkg::mbag_req_t cmd = '0, xr_q, xw_q, y_q;
    mbag_pkg::mbag_rsp_t xr_s, xw_s, y_s;
    int failures = 0, samples_checked = 0;
    initial forever #5 aclk = ~aclk;
    mbag_decode_model u_dec (.aclk(aclk), .go(go), .cmd(cmd), .x_rd_req(xr_q),
        .x_wr_req(xw_q), .y_req(y_q));
    mbag_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .x_rd_req(xr_q), .x_wr_req(xw_q),
        .y_req(y_q), .x_rd_rsp(xr_s), .x_wr_rsp(xw_s), .y_rsp(y_s));
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic ck(input string n, input logic [31:0] e, input logic [31:0] v);
        samples_checked++;
        if (v !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, v);
        end
    endtask : ck
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tv;
        tv = 1'b0;
        @(posedge aclk);
        {awaddr, araddr, wdata} <= {a, a, d};
        {awvalid, wvalid, bready} <= {w, w, w};
        {arvalid, rready} <= {!w, !w};
        for (int n = 0; n < 20 && !tv; n++) begin
            @(negedge aclk);
            ta = (w ? awvalid && awready : arvalid && arready) === 1'b1;
            tw = (wvalid && wready) === 1'b1;
            tv = (w ? bvalid : rvalid) === 1'b1;
            q = rdata;
            r = w ? bresp : rresp;
            @(posedge aclk);
            if (ta) {awvalid, arvalid} <= 2'b00;
            if (tw) wvalid <= 1'b0;
            if (tv) {bready, rready} <= 2'b00;
        end
        if (!tv) begin
            ck("bus answer", 32'h1, 32'h0);
            summarize();
        end
    endtask : bus
    task automatic gen(input int g, input logic [3:0] w, input logic [15:0] p, input logic [15:0] s,
            input mbag_pkg::mbag_mode_t m, input logic b, input logic [15:0] ea, input logic [15:0] nv);
        mbag_pkg::mbag_rsp_t o;
        @(posedge aclk);
        cmd <= '{1'b1, w, p, s, m, b};
        go <= 3'h1 << g;
        @(posedge aclk);
        go <= 3'h0;
        @(posedge aclk);
        @(negedge aclk);
        o = g == 0 ? xr_s : (g == 1 ? xw_s : y_s);
        ck("effective address", 32'(ea), 32'(o.ea));
        ck("write back", 32'(m != IN && m != OF), 32'(o.wb_en));
        if (m != IN && m != OF) ck("new pointer", 32'(nv), 32'(o.wb_val));
    endtask : gen
    task automatic t_regs;
        bus(1'b0, mbag_pkg::OFF_CTRL, 32'h0);
        ck("control reset", 32'h0FFF, q);
        bus(1'b1, mbag_pkg::OFF_XEND, 32'hABCD_2063);
        bus(1'b0, mbag_pkg::OFF_XEND, 32'h0);
        ck("end bound", 32'h2063, q);
        bus(1'b0, 8'h40, 32'h0);
        ck("unmapped response", 32'(mbag_pkg::RESP_SLVERR), 32'(r));
    endtask : t_regs
    task automatic t_xmod;
        bus(1'b1, mbag_pkg::OFF_XSTART, 32'h2000);
        bus(1'b1, mbag_pkg::OFF_CTRL, 32'h8FF2);
        gen(0, 4'h2, 16'h2060, 16'h0006, POI, 1'b0, 16'h2060, 16'h2002);
        gen(0, 4'h2, 16'h2060, 16'h00CA, PRI, 1'b0, 16'h2062, 16'h2062);
        gen(0, 4'h2, 16'h2060, 16'h0010, OF, 1'b0, 16'h200C, 16'h0);
        gen(0, 4'h2, 16'h2061, 16'h0010, IN, 1'b0, 16'h2061, 16'h0);
        gen(0, 4'h2, 16'h2000, 16'hFFFE, PRD, 1'b0, 16'h1FFE, 16'h1FFE);
        gen(1, 4'h2, 16'h2060, 16'h0006, PRI, 1'b0, 16'h2002, 16'h2002);
        gen(0, 4'h3, 16'h2060, 16'h0006, PRI, 1'b0, 16'h2066, 16'h2066);
        bus(1'b1, mbag_pkg::OFF_CTRL, 32'h0FF2);
        gen(0, 4'h2, 16'h2060, 16'h0006, PRI, 1'b0, 16'h2066, 16'h2066);
        bus(1'b1, mbag_pkg::OFF_CTRL, 32'h8FFF);
        gen(0, 4'h2, 16'h2060, 16'h0006, PRI, 1'b0, 16'h2066, 16'h2066);
        bus(1'b1, mbag_pkg::OFF_XSTART, 32'h201C);
        bus(1'b1, mbag_pkg::OFF_XEND, 32'h207F);
        bus(1'b1, mbag_pkg::OFF_CTRL, 32'h8FF2);
        gen(0, 4'h2, 16'h201C, 16'hFFFC, PRD, 1'b0, 16'h207C, 16'h207C);
        gen(0, 4'h2, 16'h207C, 16'h0008, PRI, 1'b0, 16'h2084, 16'h2084);
        bus(1'b1, mbag_pkg::OFF_XSTART, 32'h2000);
        gen(0, 4'h2, 16'h207E, 16'h0004, PRI, 1'b0, 16'h2002, 16'h2002);
        gen(0, 4'h2, 16'h2000, 16'hFFFC, PRD, 1'b0, 16'h207C, 16'h207C);
    endtask : t_xmod
    task automatic t_bitrev;
        bus(1'b1, mbag_pkg::OFF_CTRL, 32'h82F2);
        bus(1'b1, mbag_pkg::OFF_PIVOT, 32'h8008);
        gen(1, 4'h2, 16'h0010, 16'h0002, POI, 1'b0, 16'h0010, 16'h0008);
        gen(1, 4'h2, 16'h0011, 16'h0002, PRI, 1'b0, 16'h0008, 16'h0008);
        gen(0, 4'h2, 16'h207E, 16'h0004, PRI, 1'b0, 16'h2002, 16'h2002);
        gen(1, 4'h2, 16'h2010, 16'h0001, POI, 1'b1, 16'h2010, 16'h2011);
        gen(1, 4'h2, 16'h2010, 16'hFFFE, PRD, 1'b0, 16'h200E, 16'h200E);
        gen(2, 4'h2, 16'h0010, 16'h0002, POI, 1'b0, 16'h0010, 16'h0012);
        for (int i = 0; i < 15; i++) begin
            bus(1'b1, mbag_pkg::OFF_PIVOT, 32'h8000 | (32'h1 << i));
            gen(1, 4'h2, 16'h0, 16'h0002, POI, 1'b0, 16'h0, 16'h2 << i);
        end
        bus(1'b1, mbag_pkg::OFF_PIVOT, 32'h0008);
        gen(1, 4'h2, 16'h2010, 16'h0002, POI, 1'b0, 16'h2010, 16'h2012);
    endtask : t_bitrev
    task automatic t_y;
        bus(1'b1, mbag_pkg::OFF_YSTART, 32'h1000);
        bus(1'b1, mbag_pkg::OFF_YEND, 32'h100F);
        bus(1'b1, mbag_pkg::OFF_CTRL, 32'h4F3F);
        gen(2, 4'h3, 16'h100E, 16'h0004, PRI, 1'b0, 16'h1002, 16'h1002);
        gen(2, 4'h3, 16'h1005, 16'h000C, PRI, 1'b0, 16'h1000, 16'h1000);
        bus(1'b1, mbag_pkg::OFF_CTRL, 32'h0F3F);
        gen(2, 4'h3, 16'h100E, 16'h0004, PRI, 1'b0, 16'h1012, 16'h1012);
    endtask : t_y
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_xmod();
        t_bitrev();
        t_y();
        summarize();
    end
endmodule : testbench
